// file: rtl/ddr3mr_dram.sv
`timescale 1ns/10ps
module ddr3mr_dram (
    input logic ref_clk_i,
    input logic rst_n_i,
    ddr3mr_if.dram bus,
    input logic [7:0] rd_data_i,
    output logic rd_req_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    input logic hot_i,
    input logic sref_i,
    output logic [7:0] rtt_ohm_o,
    output logic wl_mode_o,
    output logic mpr_on_o,
    output logic [1:0] mpr_mode_o,
    output logic sr_double_o,
    output logic sr_tick_o,
    output logic [4:0] rd_lat_o,
    output logic [4:0] wr_lat_o
);
    typedef struct packed {
        logic [13:0] mr1;
        logic [13:0] mr2;
        logic [13:0] mr3;
        logic [ddr3mr_pkg::PIPE_W-1:0] rd_pipe;
        logic [ddr3mr_pkg::PIPE_W-1:0] wr_pipe;
        logic [2:0] rd_cnt;
        logic [2:0] wr_cnt;
        logic [7:0] dq;
        logic dq_oe;
        logic dqs;
        logic [7:0] wr_data;
        logic wr_valid;
        logic [7:0] rtt;
        logic hot_s1;
        logic hot_s2;
        logic sref_s1;
        logic sref_s2;
        logic sr_double;
        logic [15:0] sr_cnt;
        logic sr_tick;
        logic [4:0] rd_lat;
        logic [4:0] wr_lat;
    } ddr3mr_dram_st_t;

    ddr3mr_dram_st_t st_reg;
    ddr3mr_dram_st_t st_next;

    logic mpr;
    logic qoff;
    logic wlev;
    logic rd_act;
    logic wr_act;
    logic [7:0] nom_ohm;
    logic [7:0] wr_ohm;
    logic [15:0] sr_limit;

    // mpr pattern: alternating calibration pattern for mode 0, else zero
    function automatic logic [7:0] mpr_data(input logic [1:0] sel, input logic [2:0] beat);
        if (sel == 2'b00) begin
            mpr_data = beat[0] ? 8'hff : 8'h00;
        end else begin
            mpr_data = 8'h00;
        end
    endfunction

    always_comb begin
        st_next = st_reg;
        mpr = st_reg.mr3[ddr3mr_pkg::MR3_MPR_EN];
        qoff = st_reg.mr1[ddr3mr_pkg::MR1_QOFF];
        // mode register load; link reset clears only mr1
        if (!bus.rst_mem_n) begin
            st_next.mr1 = ddr3mr_pkg::MR_RST;
        end else if (bus.cmd_valid && bus.cmd == ddr3mr_pkg::CMD_MRS) begin
            case (bus.ba)
                ddr3mr_pkg::MR1_SEL: st_next.mr1 = bus.addr;
                ddr3mr_pkg::MR2_SEL: st_next.mr2 = bus.addr;
                ddr3mr_pkg::MR3_SEL: st_next.mr3 = bus.addr;
                default: ;
            endcase
        end
        st_next.rd_lat = ddr3mr_pkg::al_cycles(st_next.mr1) + ddr3mr_pkg::CAS_LAT;
        st_next.wr_lat = ddr3mr_pkg::al_cycles(st_next.mr1)
            + ddr3mr_pkg::cwl_cycles(st_next.mr2);
        // posted reads wait additive latency plus cas latency, writes additive plus cas write latency
        st_next.rd_pipe = st_reg.rd_pipe >> 1;
        st_next.wr_pipe = st_reg.wr_pipe >> 1;
        if (bus.cmd_valid && bus.cmd == ddr3mr_pkg::CMD_RD) begin
            st_next.rd_pipe = st_next.rd_pipe | ddr3mr_pkg::lat_bit(st_reg.rd_lat);
        end
        if (bus.cmd_valid && bus.cmd == ddr3mr_pkg::CMD_WR && !mpr) begin
            st_next.wr_pipe = st_next.wr_pipe | ddr3mr_pkg::lat_bit(st_reg.wr_lat);
        end
        if (st_reg.rd_pipe[0]) begin
            st_next.rd_cnt = ddr3mr_pkg::BEATS;
        end else if (st_reg.rd_cnt != 3'h0) begin
            st_next.rd_cnt = st_reg.rd_cnt - 3'h1;
        end
        if (st_reg.wr_pipe[0]) begin
            st_next.wr_cnt = ddr3mr_pkg::BEATS;
        end else if (st_reg.wr_cnt != 3'h0) begin
            st_next.wr_cnt = st_reg.wr_cnt - 3'h1;
        end
        rd_act = st_next.rd_cnt != 3'h0;
        wr_act = st_next.wr_cnt != 3'h0;
        rd_req_o = rd_act && !mpr;
        wlev = st_next.mr1[ddr3mr_pkg::MR1_WLEV];
        // read burst: array data, or calibration pattern when redirected
        if (rd_act) begin
            if (mpr) begin
                st_next.dq = mpr_data(st_reg.mr3[ddr3mr_pkg::MR3_SEL_HI:ddr3mr_pkg::MR3_SEL_LO],
                    ddr3mr_pkg::BEATS - st_next.rd_cnt);
            end else begin
                st_next.dq = rd_data_i;
            end
            st_next.dqs = ~st_reg.dqs;
            st_next.dq_oe = !qoff;
        end else if (wlev) begin
            // leveling feedback: strobe level sampled at clock returned on dq0
            st_next.dq = {7'h00, bus.dqs_w};
            st_next.dqs = 1'b0;
            st_next.dq_oe = !st_next.mr1[ddr3mr_pkg::MR1_QOFF];
        end else begin
            st_next.dq = 8'h00;
            st_next.dqs = 1'b0;
            st_next.dq_oe = 1'b0;
        end
        // write capture one edge after the controller drives each beat
        st_next.wr_valid = st_reg.wr_cnt != 3'h0;
        if (st_reg.wr_cnt != 3'h0) begin
            st_next.wr_data = bus.dq_w;
        end
        // termination selection
        nom_ohm = ddr3mr_pkg::rtt_nom_ohm(st_next.mr1);
        wr_ohm = ddr3mr_pkg::rtt_wr_ohm(st_next.mr2);
        if (!bus.odt || rd_act) begin
            st_next.rtt = 8'h00;
        end else if (wr_act && wr_ohm != 8'h00 && !wlev) begin
            st_next.rtt = wr_ohm;
        end else begin
            st_next.rtt = nom_ohm;
        end
        // self refresh rate
        st_next.hot_s1 = hot_i;
        st_next.hot_s2 = st_reg.hot_s1;
        st_next.sref_s1 = sref_i;
        st_next.sref_s2 = st_reg.sref_s1;
        st_next.sr_double = st_reg.mr2[ddr3mr_pkg::MR2_SRT]
            || (st_reg.mr2[ddr3mr_pkg::MR2_ASR] && st_reg.hot_s2);
        sr_limit = st_reg.sr_double ? (ddr3mr_pkg::REFI_CYC >> 1) : ddr3mr_pkg::REFI_CYC;
        st_next.sr_tick = 1'b0;
        if (!st_reg.sref_s2) begin
            st_next.sr_cnt = 16'h0000;
        end else if (st_reg.sr_cnt >= sr_limit - 16'h0001) begin
            st_next.sr_cnt = 16'h0000;
            st_next.sr_tick = 1'b1;
        end else begin
            st_next.sr_cnt = st_reg.sr_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.dq_d = st_reg.dq;
    assign bus.dq_d_oe = st_reg.dq_oe;
    assign bus.dqs_d = st_reg.dqs;
    assign bus.dqs_n_d = ~st_reg.dqs;
    assign bus.dqs_d_oe = st_reg.dq_oe && (st_reg.rd_cnt != 3'h0);
    assign wr_data_o = st_reg.wr_data;
    assign wr_valid_o = st_reg.wr_valid;
    assign rtt_ohm_o = st_reg.rtt;
    assign wl_mode_o = st_reg.mr1[ddr3mr_pkg::MR1_WLEV];
    assign mpr_on_o = st_reg.mr3[ddr3mr_pkg::MR3_MPR_EN];
    assign mpr_mode_o = st_reg.mr3[ddr3mr_pkg::MR3_SEL_HI:ddr3mr_pkg::MR3_SEL_LO];
    assign sr_double_o = st_reg.sr_double;
    assign sr_tick_o = st_reg.sr_tick;
    assign rd_lat_o = st_reg.rd_lat;
    assign wr_lat_o = st_reg.wr_lat;
endmodule

// file: rtl/ddr3mr_pkg.sv
package ddr3mr_pkg;
    localparam logic [1:0] MR1_SEL = 2'h1;
    localparam logic [1:0] MR2_SEL = 2'h2;
    localparam logic [1:0] MR3_SEL = 2'h3;
    localparam int MR1_QOFF = 12;
    localparam int MR1_WLEV = 7;
    localparam int MR1_RTT2 = 9;
    localparam int MR1_RTT1 = 6;
    localparam int MR1_RTT0 = 2;
    localparam int MR1_AL_HI = 4;
    localparam int MR1_AL_LO = 3;
    localparam int MR2_CWL_HI = 5;
    localparam int MR2_CWL_LO = 3;
    localparam int MR2_ASR = 6;
    localparam int MR2_SRT = 7;
    localparam int MR2_RWR_HI = 10;
    localparam int MR2_RWR_LO = 9;
    localparam int MR3_MPR_EN = 2;
    localparam int MR3_SEL_HI = 1;
    localparam int MR3_SEL_LO = 0;
    localparam logic [13:0] MR_RST = 14'h0000;
    localparam logic [4:0] CAS_LAT = 5'h06;
    localparam logic [4:0] CWL_BASE = 5'h05;
    localparam logic [2:0] BEATS = 3'h4;
    localparam int PIPE_W = 32;
    localparam int RZQ_OHM = 240;
    localparam logic [4:0] TMOD_CYC = 5'h0c;
    localparam logic [15:0] REFI_CYC = 16'h030c;
    localparam logic MIL_GRADE = 1'b0;
    localparam logic [1:0] RATE_1X = 2'h0;
    localparam logic [1:0] RATE_2X = 2'h1;
    localparam logic [1:0] RATE_4X = 2'h2;
    localparam logic [1:0] ZONE_HOT = 2'h1;
    localparam logic [1:0] ZONE_HIGH = 2'h2;

    typedef enum logic [1:0] {
        CMD_NOP = 2'b00,
        CMD_MRS = 2'b01,
        CMD_RD = 2'b10,
        CMD_WR = 2'b11
    } ddr3mr_cmd_t;

    function automatic logic [4:0] al_cycles(input logic [13:0] mr1);
        case (mr1[MR1_AL_HI:MR1_AL_LO])
            2'b01: al_cycles = CAS_LAT - 5'h01;
            2'b10: al_cycles = CAS_LAT - 5'h02;
            default: al_cycles = 5'h00;
        endcase
    endfunction

    function automatic logic [4:0] cwl_cycles(input logic [13:0] mr2);
        cwl_cycles = CWL_BASE + {2'b00, mr2[MR2_CWL_HI:MR2_CWL_LO]};
    endfunction

    function automatic logic [7:0] rtt_nom_ohm(input logic [13:0] mr1);
        case ({mr1[MR1_RTT2], mr1[MR1_RTT1], mr1[MR1_RTT0]})
            3'b001: rtt_nom_ohm = 8'(RZQ_OHM / 4);
            3'b010: rtt_nom_ohm = 8'(RZQ_OHM / 2);
            3'b011: rtt_nom_ohm = 8'(RZQ_OHM / 6);
            3'b100: rtt_nom_ohm = 8'(RZQ_OHM / 12);
            3'b101: rtt_nom_ohm = 8'(RZQ_OHM / 8);
            default: rtt_nom_ohm = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rtt_wr_ohm(input logic [13:0] mr2);
        case (mr2[MR2_RWR_HI:MR2_RWR_LO])
            2'b01: rtt_wr_ohm = 8'(RZQ_OHM / 4);
            2'b10: rtt_wr_ohm = 8'(RZQ_OHM / 2);
            default: rtt_wr_ohm = 8'h00;
        endcase
    endfunction

    function automatic logic [PIPE_W-1:0] lat_bit(input logic [4:0] lat);
        lat_bit = {{(PIPE_W-1){1'b0}}, 1'b1} << (lat - 5'h01);
    endfunction
endpackage

// file: rtl/ddr3mr_if.sv
`timescale 1ns/10ps
interface ddr3mr_if;
    logic cmd_valid;
    logic [1:0] cmd;
    logic [1:0] ba;
    logic [13:0] addr;
    logic odt;
    logic rst_mem_n;
    logic [7:0] dq_c;
    logic dq_c_oe;
    logic dqs_c;
    logic dqs_c_oe;
    logic [7:0] dq_d;
    logic dq_d_oe;
    logic dqs_d;
    logic dqs_n_d;
    logic dqs_d_oe;
    wire [7:0] dq_w;
    wire dqs_w;
    // released lines read as pulled low
    assign dq_w = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : 8'h00);
    assign dqs_w = dqs_d_oe ? dqs_d : (dqs_c_oe ? dqs_c : 1'b0);
    modport ctrl (
        output cmd_valid, cmd, ba, addr, odt, rst_mem_n, dq_c, dq_c_oe, dqs_c, dqs_c_oe,
        input dq_w, dqs_w
    );
    modport dram (
        input cmd_valid, cmd, ba, addr, odt, rst_mem_n, dq_w, dqs_w,
        output dq_d, dq_d_oe, dqs_d, dqs_n_d, dqs_d_oe
    );
endinterface

// file: rtl/ddr3mr_ctrl.sv
`timescale 1ns/10ps
module ddr3mr_ctrl (
    input logic ref_clk_i,
    input logic rst_n_i,
    ddr3mr_if.ctrl bus,
    input logic req_valid_i,
    input logic [1:0] req_cmd_i,
    input logic [1:0] req_ba_i,
    input logic [13:0] req_addr_i,
    output logic req_ready_o,
    input logic [7:0] wr_data_i,
    output logic wr_req_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input logic odt_want_i,
    input logic cal_done_i,
    input logic wl_dqs_i,
    input logic mem_reset_n_i,
    input logic [1:0] temp_zone_i,
    output logic [1:0] refresh_rate_o,
    output logic mpr_on_o
);
    typedef struct packed {
        logic [13:0] mr1;
        logic [13:0] mr2;
        logic [13:0] mr3;
        logic cmd_v;
        logic [1:0] cmd;
        logic [1:0] ba;
        logic [13:0] addr;
        logic [4:0] gap;
        logic [ddr3mr_pkg::PIPE_W-1:0] rd_pipe;
        logic [ddr3mr_pkg::PIPE_W-1:0] wr_pipe;
        logic [2:0] rd_cnt;
        logic [2:0] wr_cnt;
        logic [7:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic odt;
        logic rst_mem_n;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [1:0] rate;
    } ddr3mr_ctrl_st_t;

    ddr3mr_ctrl_st_t st_reg;
    ddr3mr_ctrl_st_t st_next;
    logic quiet;
    logic mpr;
    logic legal;
    logic wlev;
    logic [4:0] al;

    always_comb begin
        st_next = st_reg;
        mpr = st_reg.mr3[ddr3mr_pkg::MR3_MPR_EN];
        wlev = st_reg.mr1[ddr3mr_pkg::MR1_WLEV];
        al = ddr3mr_pkg::al_cycles(st_reg.mr1);
        quiet = st_reg.rd_pipe == '0 && st_reg.wr_pipe == '0 && st_reg.rd_cnt == 3'h0
            && st_reg.wr_cnt == 3'h0 && !st_reg.cmd_v;
        case (req_cmd_i)
            ddr3mr_pkg::CMD_MRS: begin
                legal = quiet && (!mpr || req_ba_i == ddr3mr_pkg::MR3_SEL);
            end
            ddr3mr_pkg::CMD_WR: legal = !mpr;
            default: legal = 1'b1;
        endcase
        req_ready_o = st_reg.gap == 5'h00 && legal;
        st_next.cmd_v = 1'b0;
        st_next.cmd = ddr3mr_pkg::CMD_NOP;
        if (st_reg.gap != 5'h00) begin
            st_next.gap = st_reg.gap - 5'h01;
        end
        if (req_valid_i && req_ready_o && req_cmd_i != ddr3mr_pkg::CMD_NOP) begin
            st_next.cmd_v = 1'b1;
            st_next.cmd = req_cmd_i;
            st_next.ba = req_ba_i;
            st_next.addr = req_addr_i;
            if (req_cmd_i == ddr3mr_pkg::CMD_MRS) begin
                st_next.gap = ddr3mr_pkg::TMOD_CYC;
                if (req_ba_i == ddr3mr_pkg::MR2_SEL) begin
                    if (req_addr_i[ddr3mr_pkg::MR2_ASR]) begin
                        st_next.addr[ddr3mr_pkg::MR2_SRT] = 1'b0;
                    end else if (temp_zone_i == ddr3mr_pkg::ZONE_HOT) begin
                        st_next.addr[ddr3mr_pkg::MR2_SRT] = 1'b1;
                    end
                end
            end else begin
                st_next.gap = {2'b00, ddr3mr_pkg::BEATS} - 5'h01;
            end
        end
        // shadow of device mode registers, updated as the device sees them
        st_next.rst_mem_n = mem_reset_n_i;
        if (!st_reg.rst_mem_n) begin
            st_next.mr1 = ddr3mr_pkg::MR_RST;
        end else if (st_reg.cmd_v && st_reg.cmd == ddr3mr_pkg::CMD_MRS) begin
            case (st_reg.ba)
                ddr3mr_pkg::MR1_SEL: st_next.mr1 = st_reg.addr;
                ddr3mr_pkg::MR2_SEL: st_next.mr2 = st_reg.addr;
                ddr3mr_pkg::MR3_SEL: st_next.mr3 = st_reg.addr;
                default: ;
            endcase
        end
        st_next.rd_pipe = st_reg.rd_pipe >> 1;
        st_next.wr_pipe = st_reg.wr_pipe >> 1;
        if (st_reg.cmd_v && st_reg.cmd == ddr3mr_pkg::CMD_RD) begin
            st_next.rd_pipe = st_next.rd_pipe | ddr3mr_pkg::lat_bit(al + ddr3mr_pkg::CAS_LAT);
        end
        if (st_reg.cmd_v && st_reg.cmd == ddr3mr_pkg::CMD_WR) begin
            st_next.wr_pipe = st_next.wr_pipe
                | ddr3mr_pkg::lat_bit(al + ddr3mr_pkg::cwl_cycles(st_reg.mr2));
        end
        st_next.rd_cnt = st_reg.rd_pipe[0] ? ddr3mr_pkg::BEATS
            : (st_reg.rd_cnt != 3'h0 ? st_reg.rd_cnt - 3'h1 : 3'h0);
        st_next.wr_cnt = st_reg.wr_pipe[0] ? ddr3mr_pkg::BEATS
            : (st_reg.wr_cnt != 3'h0 ? st_reg.wr_cnt - 3'h1 : 3'h0);
        st_next.rd_valid = st_reg.rd_cnt != 3'h0;
        if (st_reg.rd_cnt != 3'h0) begin
            st_next.rd_data = bus.dq_w;
        end
        wr_req_o = st_next.wr_cnt != 3'h0;
        st_next.dq = wr_req_o ? wr_data_i : 8'h00;
        st_next.dq_oe = wr_req_o;
        st_next.dqs = wr_req_o ? ~st_reg.dqs : (wlev && wl_dqs_i);
        st_next.dqs_oe = wr_req_o || wlev;
        // termination off while a read is in flight
        st_next.odt = odt_want_i && cal_done_i && st_reg.rd_pipe == '0
            && st_next.rd_cnt == 3'h0;
        if (ddr3mr_pkg::MIL_GRADE || temp_zone_i >= ddr3mr_pkg::ZONE_HIGH) begin
            st_next.rate = ddr3mr_pkg::RATE_4X;
        end else if (temp_zone_i == ddr3mr_pkg::ZONE_HOT) begin
            st_next.rate = ddr3mr_pkg::RATE_2X;
        end else begin
            st_next.rate = ddr3mr_pkg::RATE_1X;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.cmd_valid = st_reg.cmd_v;
    assign bus.cmd = st_reg.cmd;
    assign bus.ba = st_reg.ba;
    assign bus.addr = st_reg.addr;
    assign bus.odt = st_reg.odt;
    assign bus.rst_mem_n = st_reg.rst_mem_n;
    assign bus.dq_c = st_reg.dq;
    assign bus.dq_c_oe = st_reg.dq_oe;
    assign bus.dqs_c = st_reg.dqs;
    assign bus.dqs_c_oe = st_reg.dqs_oe;
    assign rd_data_o = st_reg.rd_data;
    assign rd_valid_o = st_reg.rd_valid;
    assign refresh_rate_o = st_reg.rate;
    assign mpr_on_o = mpr;
endmodule

// file: sim/ddr3mr_checker.sv
`timescale 1ns/10ps
module ddr3mr_checker (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic cmd_valid,
    input logic [1:0] cmd,
    input logic [1:0] ba,
    input logic [13:0] addr,
    input logic rst_mem_n,
    input logic dq_c_oe,
    input logic dq_d_oe,
    input logic dqs_d_oe,
    input logic dqs_d,
    input logic dqs_n_d,
    input logic [7:0] dq_w
);
    typedef struct packed {
        logic qoff;
        logic [1:0] al;
        logic [2:0] cwl;
        logic mpr;
        logic [1:0] mode;
    } ddr3mr_chk_t;
    ddr3mr_chk_t st_reg, st_next;
    logic mrs, rd, wr;
    assign mrs = cmd_valid && cmd == ddr3mr_pkg::CMD_MRS;
    assign rd = cmd_valid && cmd == ddr3mr_pkg::CMD_RD;
    assign wr = cmd_valid && cmd == ddr3mr_pkg::CMD_WR;
    // shadow of the mode bits seen on the command bus
    always_comb begin
        st_next = st_reg;
        if (mrs && ba == ddr3mr_pkg::MR1_SEL) begin
            st_next.qoff = addr[12];
            st_next.al = addr[4:3];
        end
        if (mrs && ba == ddr3mr_pkg::MR2_SEL) begin
            st_next.cwl = addr[5:3];
        end
        if (mrs && ba == ddr3mr_pkg::MR3_SEL) begin
            st_next.mpr = addr[2];
            st_next.mode = addr[1:0];
        end
        if (!rst_mem_n) begin
            st_next.qoff = 1'b0;
            st_next.al = 2'h0;
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    qoff_float_a: assert property (st_reg.qoff |-> !dq_d_oe && !dqs_d_oe)
        else $error("outputs driven while disabled");
    strobe_pair_a: assert property (dqs_d_oe |-> dqs_n_d == !dqs_d)
        else $error("strobe pair not complementary");
    read_al0_a: assert property (rd && st_reg.al == 2'h0 && !st_reg.qoff
        |-> ##7 dq_d_oe [*4])
        else $error("read burst late with zero additive latency");
    read_al1_a: assert property (rd && st_reg.al == 2'h1 && !st_reg.qoff
        |-> ##12 dq_d_oe [*4])
        else $error("read burst late with additive latency cl-1");
    write_lat_a: assert property (wr && st_reg.al == 2'h0 && st_reg.cwl == 3'h0
        |-> ##6 dq_c_oe [*4])
        else $error("write data not at write latency");
    mpr_data_a: assert property (rd && st_reg.mpr && st_reg.mode == 2'h0
        && st_reg.al == 2'h0
        && !st_reg.qoff |-> ##7 dq_w == 8'h00 ##1 dq_w == 8'hff ##1 dq_w == 8'h00
        ##1 dq_w == 8'hff)
        else $error("calibration pattern wrong");
    col_gap_a: assert property (cmd_valid && cmd[1] |=> (!cmd_valid) [*3])
        else $error("column commands too close");
    mrs_gap_a: assert property (mrs |=> (!cmd_valid) [*8] ##1 (!cmd_valid) [*3])
        else $error("command too soon after mode set");
    mpr_only_a: assert property (cmd_valid && st_reg.mpr |-> cmd == ddr3mr_pkg::CMD_RD
        || (mrs && ba == ddr3mr_pkg::MR3_SEL))
        else $error("non-read command while calibration register on");
    cover property (rd && st_reg.mpr);
    cover property (rd && st_reg.qoff);
    cover property (rd && st_reg.al == 2'h1);
    cover property (wr && st_reg.al == 2'h0 && st_reg.cwl == 3'h0);
endmodule

// file: sim/ddr3_mode_register_functions_tb.sv
`timescale 1ns/10ps
module ddr3_mode_register_functions_tb;
    logic ref_clk_i, rst_n_i, req_valid, req_ready, wr_req, rd_valid, odt_want, cal_done;
    logic wl_dqs, mem_reset_n, c_mpr, rd_req, cap_valid, hot, sref, wl_mode, d_mpr;
    logic sr_double, sr_tick, mute;
    logic [1:0] req_cmd, req_ba, temp_zone, rrate, mpr_mode;
    logic [13:0] req_addr;
    logic [7:0] wr_data, rd_data, arr_data, cap_data, rtt, al;
    logic [4:0] rd_lat, wr_lat;
    logic [2:0] cw;
    int bad_count, checks, i, n;
    logic [7:0] rd_q[$];
    logic [7:0] wr_q[$];
    logic [7:0] nom_tab[6] = '{8'h00, 8'h3c, 8'h78, 8'h28, 8'h14, 8'h1e};
    ddr3mr_if u_ddr3mr_if ();
    ddr3mr_ctrl u_ddr3mr_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(u_ddr3mr_if),
        .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_ba_i(req_ba), .req_addr_i(req_addr),
        .req_ready_o(req_ready), .wr_data_i(wr_data), .wr_req_o(wr_req), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .odt_want_i(odt_want), .cal_done_i(cal_done), .wl_dqs_i(wl_dqs),
        .mem_reset_n_i(mem_reset_n), .temp_zone_i(temp_zone), .refresh_rate_o(rrate),
        .mpr_on_o(c_mpr));
    ddr3mr_dram u_ddr3mr_dram (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(u_ddr3mr_if),
        .rd_data_i(arr_data), .rd_req_o(rd_req), .wr_data_o(cap_data), .wr_valid_o(cap_valid),
        .hot_i(hot), .sref_i(sref), .rtt_ohm_o(rtt), .wl_mode_o(wl_mode), .mpr_on_o(d_mpr),
        .mpr_mode_o(mpr_mode), .sr_double_o(sr_double), .sr_tick_o(sr_tick),
        .rd_lat_o(rd_lat), .wr_lat_o(wr_lat));
    ddr3mr_checker u_ddr3mr_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .cmd_valid(u_ddr3mr_if.cmd_valid), .cmd(u_ddr3mr_if.cmd), .ba(u_ddr3mr_if.ba),
        .addr(u_ddr3mr_if.addr), .rst_mem_n(u_ddr3mr_if.rst_mem_n),
        .dq_c_oe(u_ddr3mr_if.dq_c_oe), .dq_d_oe(u_ddr3mr_if.dq_d_oe),
        .dqs_d_oe(u_ddr3mr_if.dqs_d_oe), .dqs_d(u_ddr3mr_if.dqs_d),
        .dqs_n_d(u_ddr3mr_if.dqs_n_d), .dq_w(u_ddr3mr_if.dq_w));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic [1:0] c, input logic [1:0] b, input logic [13:0] a, int gap);
        int k;
        @(negedge ref_clk_i);
        req_valid = 1'b1;
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        #1;
        for (k = 0; k < 60 && req_ready !== 1'b1; k++) @(negedge ref_clk_i);
        if (k == 60) begin
            bad_count++;
            results();
        end
        @(negedge ref_clk_i);
        req_valid = 1'b0;
        repeat (gap) @(negedge ref_clk_i);
    endtask
    task automatic mrs(input logic [1:0] b, input logic [13:0] a);
        req(ddr3mr_pkg::CMD_MRS, b, a, 14);
    endtask
    always @(negedge ref_clk_i) begin
        arr_data <= 8'($urandom);
        wr_data <= 8'($urandom);
        wl_dqs <= 1'($urandom);
    end
    // expected data noted when the driver side hands it over
    always @(posedge ref_clk_i) begin
        if (rd_req && !mute) rd_q.push_back(arr_data);
        if (wr_req && !mute) wr_q.push_back(wr_data);
        if (rd_valid && !mute) begin
            chk(16'(rd_data), 16'(rd_q.size() ? rd_q.pop_front() : 8'hxx));
        end
        if (cap_valid && !mute) begin
            chk(16'(cap_data), 16'(wr_q.size() ? wr_q.pop_front() : 8'hxx));
        end
    end
    initial begin
        #500000;
        bad_count++;
        results();
    end
    initial begin
        {rst_n_i, req_valid, req_cmd, req_ba, req_addr, odt_want, cal_done} = '0;
        {mem_reset_n, temp_zone, hot, sref, mute, bad_count, checks} = '0;
        {arr_data, wr_data, wl_dqs} = '0;
        n = $urandom(77959);
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        mem_reset_n = 1'b1;
        cal_done = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        for (i = 0; i < 4; i++) begin
            cw = 3'($urandom_range(0, 3));
            mrs(ddr3mr_pkg::MR2_SEL, {8'h00, cw, 3'h0});
            mrs(ddr3mr_pkg::MR1_SEL, {9'h000, i[1:0], 3'h0});
            al = (i == 1) ? 8'h05 : (i == 2) ? 8'h04 : 8'h00;
            chk(16'(rd_lat), 16'(al + 8'h06));
            chk(16'(wr_lat), 16'(al + 8'h05 + 8'(cw)));
            req(ddr3mr_pkg::CMD_WR, 2'($urandom), 14'($urandom), 4);
            req(ddr3mr_pkg::CMD_WR, 2'($urandom), 14'($urandom), 12);
            req(ddr3mr_pkg::CMD_RD, 2'($urandom), 14'($urandom), 4);
            req(ddr3mr_pkg::CMD_RD, 2'($urandom), 14'($urandom), 24);
        end
        mrs(ddr3mr_pkg::MR1_SEL, 14'h0008);
        mem_reset_n = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        mem_reset_n = 1'b1;
        for (n = 0; n < 40 && rd_lat !== 5'h06; n++) @(negedge ref_clk_i);
        chk(16'(rd_lat), 16'h0006);
        chk(16'(wr_lat), 16'(8'h05 + 8'(cw)));
        repeat (2) @(negedge ref_clk_i);
        odt_want = 1'b1;
        for (i = 1; i < 6; i++) begin
            mrs(ddr3mr_pkg::MR1_SEL, {4'h0, i[2], 2'h0, i[1], 3'h0, i[0], 2'h0});
            for (n = 0; n < 40 && rtt !== nom_tab[i]; n++) @(negedge ref_clk_i);
            chk(16'(rtt), 16'(nom_tab[i]));
        end
        odt_want = 1'b0;
        for (n = 0; n < 40 && rtt !== 8'h00; n++) @(negedge ref_clk_i);
        chk(16'(rtt), 16'h0000);
        odt_want = 1'b1;
        mrs(ddr3mr_pkg::MR1_SEL, 14'h0000);
        mrs(ddr3mr_pkg::MR2_SEL, 14'h0400);
        req(ddr3mr_pkg::CMD_WR, 2'h0, 14'($urandom), 0);
        for (n = 0; n < 40 && rtt !== 8'h78; n++) @(negedge ref_clk_i);
        chk(16'(rtt), 16'h0078);
        for (n = 0; n < 40 && rtt !== 8'h00; n++) @(negedge ref_clk_i);
        chk(16'(rtt), 16'h0000);
        repeat (10) @(negedge ref_clk_i);
        mute = 1'b1;
        mrs(ddr3mr_pkg::MR1_SEL, 14'h0080);
        chk(16'(wl_mode), 16'h0001);
        req(ddr3mr_pkg::CMD_WR, 2'h0, 14'($urandom), 0);
        i = 0;
        for (n = 0; n < 30; n++) begin
            @(negedge ref_clk_i);
            if (rtt === 8'h78) i++;
        end
        chk(16'(i), 16'h0000);
        mrs(ddr3mr_pkg::MR1_SEL, 14'h1000);
        req(ddr3mr_pkg::CMD_RD, 2'h0, 14'($urandom), 24);
        mrs(ddr3mr_pkg::MR1_SEL, 14'h0000);
        rd_q.delete();
        wr_q.delete();
        mute = 1'b0;
        for (i = 0; i < 2; i++) begin
            mrs(ddr3mr_pkg::MR3_SEL, {12'h001, i[1:0]});
            chk(16'({d_mpr, c_mpr, mpr_mode}), 16'({2'h3, i[1:0]}));
            for (n = 0; n < 4; n++) rd_q.push_back((i == 0 && n[0]) ? 8'hff : 8'h00);
            req(ddr3mr_pkg::CMD_RD, 2'h0, 14'h0000, 24);
            chk(16'(rd_q.size()), 16'h0000);
        end
        @(negedge ref_clk_i);
        req_valid = 1'b1;
        req_cmd = ddr3mr_pkg::CMD_WR;
        @(negedge ref_clk_i);
        chk(16'(req_ready), 16'h0000);
        req_valid = 1'b0;
        mrs(ddr3mr_pkg::MR3_SEL, 14'h0000);
        chk(16'({d_mpr, c_mpr}), 16'h0000);
        sref = 1'b1;
        mrs(ddr3mr_pkg::MR2_SEL, 14'h0080);
        for (n = 0; n < 40 && sr_double !== 1'b1; n++) @(negedge ref_clk_i);
        chk(16'(sr_double), 16'h0001);
        for (n = 0; n < 1000 && sr_tick !== 1'b1; n++) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        for (n = 1; n < 1000 && sr_tick !== 1'b1; n++) @(negedge ref_clk_i);
        chk(16'(n), ddr3mr_pkg::REFI_CYC >> 1);
        for (i = 0; i < 4; i++) begin
            if (i == 0) mrs(ddr3mr_pkg::MR2_SEL, 14'h00c0);
            if (i == 3) mrs(ddr3mr_pkg::MR2_SEL, 14'h0000);
            hot = i[0];
            repeat (4) @(negedge ref_clk_i);
            for (n = 0; n < 40 && sr_double !== (i[0] && i < 3); n++) @(negedge ref_clk_i);
            chk(16'(sr_double), 16'(i[0] && i < 3));
        end
        for (i = 0; i < 3; i++) begin
            temp_zone = i[1:0];
            al = (i == 0) ? 8'(ddr3mr_pkg::RATE_1X) : (i == 1) ? 8'(ddr3mr_pkg::RATE_2X)
                : 8'(ddr3mr_pkg::RATE_4X);
            for (n = 0; n < 40 && 8'(rrate) !== al; n++) @(negedge ref_clk_i);
            chk(16'(rrate), 16'(al));
            if (i == 1) begin
                mrs(ddr3mr_pkg::MR2_SEL, 14'h0000);
                chk(16'(sr_double), 16'h0001);
            end
        end
        results();
    end
endmodule
